// >>> src/fcrc_device_end.sv
`timescale 1ns/1ns
`include "fcrc_map.svh"
// Overview of operation
// - Command register payload: code, top address, options
// - Write without reply stores consecutive registers
// - Request with reply writes nothing and returns register contents
// - Never seven payload bytes in a frame
// - Check uses x16 + x15 + x2 + 1
// - Receiver checks whole frame for zero remainder
// - Check over frame bytes, LSB first
// - Check register cleared before each frame
// - Augmented form appends sixteen zero bits
// - Fixed per-bit shift and xor update
// - Low check byte sent first, high last
// - First byte bit 7 gives frame kind
// - Reply length field holds payload count minus one
module fcrc_device_end (
	input wire logic clock, // 125 MHz
	input wire logic rst_b, // async reset, active low
	fcrc_link_if.device lk, // frame link
	input wire logic [7:0] my_addr, // own device address
	input wire logic [7:0] my_group, // own group id
	input wire logic [7:0] rd_data, // read value, one cycle after rd_en
	output logic rd_en, // register read pulse
	output logic [15:0] rd_addr, // register read address
	output logic wr_en, // register write pulse
	output logic [15:0] wr_addr, // register write address
	output logic [7:0] wr_data, // register write value
	output logic cmd_go, // command received pulse
	output logic [7:0] cmd_code, // command code
	output logic [7:0] cmd_top_addr, // highest responding address
	output logic chsel_load, // new channel select pulse
	output logic [31:0] chsel_value, // channel select, first byte in 31:24
	output logic avg_load, // new averaging value pulse
	output logic [7:0] avg_value, // averaging value
	output logic comm_err // bad check pulse
);
	fcrc_pkg::fcrc_dev_st_e st_reg, st_next;
	logic [7:0] idx_reg, idx_next, init_reg, init_next, dev_reg, dev_next, cnt_reg, cnt_next;
	logic [15:0] ra_reg, ra_next, crc_reg, crc_next, crc_v;
	logic [7:0] dat_reg [8];
	logic [7:0] dat_next [8];
	logic [6:0] last_reg, last_next, rlen;
	logic [7:0] tx_reg, tx_next, wd_reg, wd_next, code_reg, code_next, top_reg, top_next, avg_reg, avg_next;
	logic txv_reg, txv_next, rde_reg, rde_next, wre_reg, wre_next, go_reg, go_next;
	logic chl_reg, chl_next, avl_reg, avl_next, err_reg, err_next;
	logic [15:0] rda_reg, rda_next, wra_reg, wra_next;
	logic [31:0] ch_reg, ch_next;
	logic kind, has_dev, accept;
	logic [1:0] rt;
	logic [3:0] n_dat;
	logic [7:0] o_dat, total, doff;

	assign kind = init_reg[`FCRC_KIND_BIT];
	assign rt = init_reg[`FCRC_REQ_HI:`FCRC_REQ_MID];
	assign has_dev = rt != `FCRC_REQ_BCAST;
	assign n_dat = fcrc_pkg::data_count(init_reg[`FCRC_DSIZE_HI:0]);
	assign o_dat = 8'(has_dev) + 8'(init_reg[`FCRC_ASIZE_BIT]) + `FCRC_HDR_MIN;
	// Length follows from the first byte alone, for both frame kinds
	assign total = kind ? o_dat + {4'h0, n_dat} + `FCRC_CRC_BYTES
		: {1'b0, init_reg[`FCRC_RLEN_HI:0]} + `FCRC_REPLY_OVH;
	assign doff = idx_reg - o_dat;
	assign accept = kind && ((rt == `FCRC_REQ_SINGLE && dev_reg == my_addr)
		|| (rt == `FCRC_REQ_GROUP && dev_reg == my_group) || rt == `FCRC_REQ_BCAST);

	always_comb begin
		st_next = st_reg;
		idx_next = idx_reg;
		init_next = init_reg;
		dev_next = dev_reg;
		ra_next = ra_reg;
		dat_next = dat_reg;
		crc_next = crc_reg;
		cnt_next = cnt_reg;
		last_next = last_reg;
		tx_next = tx_reg;
		txv_next = 1'b0;
		rde_next = 1'b0;
		rda_next = rda_reg;
		wre_next = 1'b0;
		wra_next = wra_reg;
		wd_next = wd_reg;
		go_next = 1'b0;
		code_next = code_reg;
		top_next = top_reg;
		chl_next = 1'b0;
		ch_next = ch_reg;
		avl_next = 1'b0;
		avg_next = avg_reg;
		err_next = 1'b0;
		crc_v = crc_reg;
		rlen = (n_dat == 4'h0) ? 7'h00 : dat_reg[0][6:0];
		unique case (st_reg)
			fcrc_pkg::FCRC_D_RX: begin
				if (lk.cmd_valid) begin
					crc_v = fcrc_pkg::crc_byte((idx_reg == 8'h00) ? `FCRC_CRC_INIT : crc_reg, lk.cmd_byte);
					crc_next = crc_v;
					idx_next = idx_reg + 8'h01;
					if (idx_reg == 8'h00) begin
						init_next = lk.cmd_byte;
						ra_next = 16'h0000;
					end else if (kind && has_dev && idx_reg == 8'h01) begin
						dev_next = lk.cmd_byte;
					end else if (kind && idx_reg < o_dat) begin
						ra_next = {ra_reg[7:0], lk.cmd_byte};
					end else if (kind && doff < {4'h0, n_dat}) begin
						dat_next[doff[2:0]] = lk.cmd_byte;
					end
					if (idx_reg != 8'h00 && idx_reg == total - 8'h01) begin
						idx_next = 8'h00;
						// Nothing is acted on until the whole frame has passed the check
						if (crc_v != `FCRC_CRC_INIT) begin
							err_next = 1'b1;
						end else if (accept && ra_reg == `FCRC_REG_CMD) begin
							go_next = 1'b1;
							code_next = dat_reg[0];
							top_next = dat_reg[1];
							chl_next = n_dat >= `FCRC_CMD_CHSEL_MIN;
							ch_next = {dat_reg[2], dat_reg[3], dat_reg[4], dat_reg[5]};
							avl_next = n_dat >= `FCRC_CMD_AVG_MIN;
							avg_next = dat_reg[6];
						end else if (accept && init_reg[`FCRC_NOREPLY_BIT]) begin
							cnt_next = 8'h00;
							if (n_dat != 4'h0) begin
								st_next = fcrc_pkg::FCRC_D_WRITE;
							end
						end else if (accept) begin
							st_next = fcrc_pkg::FCRC_D_RHDR;
						end
					end
				end
			end
			fcrc_pkg::FCRC_D_WRITE: begin
				wre_next = 1'b1;
				wra_next = ra_reg + {8'h00, cnt_reg};
				wd_next = dat_reg[cnt_reg[2:0]];
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == {4'h0, n_dat} - 8'h01) begin
					st_next = fcrc_pkg::FCRC_D_RX;
				end
			end
			fcrc_pkg::FCRC_D_RHDR: begin
				// A seven-byte reply cannot be described, so one more register is read
				last_next = (rlen == `FCRC_RLEN_SEVEN) ? `FCRC_RLEN_EIGHT : rlen;
				tx_next = {1'b0, last_next};
				txv_next = 1'b1;
				crc_next = fcrc_pkg::crc_byte(`FCRC_CRC_INIT, tx_next);
				cnt_next = 8'h00;
				st_next = fcrc_pkg::FCRC_D_RREQ;
			end
			fcrc_pkg::FCRC_D_RREQ: begin
				rde_next = 1'b1;
				rda_next = ra_reg + {8'h00, cnt_reg};
				st_next = fcrc_pkg::FCRC_D_RWAIT;
			end
			fcrc_pkg::FCRC_D_RWAIT: begin
				st_next = fcrc_pkg::FCRC_D_RCAP;
			end
			fcrc_pkg::FCRC_D_RCAP: begin
				tx_next = rd_data;
				txv_next = 1'b1;
				crc_next = fcrc_pkg::crc_byte(crc_reg, rd_data);
				cnt_next = cnt_reg + 8'h01;
				st_next = (cnt_reg == {1'b0, last_reg}) ? fcrc_pkg::FCRC_D_CRCL : fcrc_pkg::FCRC_D_RREQ;
			end
			fcrc_pkg::FCRC_D_CRCL: begin
				crc_next = fcrc_pkg::crc_aug(crc_reg);
				tx_next = crc_next[7:0];
				txv_next = 1'b1;
				st_next = fcrc_pkg::FCRC_D_CRCH;
			end
			fcrc_pkg::FCRC_D_CRCH: begin
				tx_next = crc_reg[15:8];
				txv_next = 1'b1;
				st_next = fcrc_pkg::FCRC_D_RX;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= fcrc_pkg::FCRC_D_RX;
			idx_reg <= 8'h00;
			init_reg <= 8'h00;
			dev_reg <= 8'h00;
			ra_reg <= 16'h0000;
			for (int i = 0; i < 8; i++) begin
				dat_reg[i] <= 8'h00;
			end
			crc_reg <= `FCRC_CRC_INIT;
			cnt_reg <= 8'h00;
			last_reg <= 7'h00;
			tx_reg <= 8'h00;
			txv_reg <= 1'b0;
			rde_reg <= 1'b0;
			rda_reg <= 16'h0000;
			wre_reg <= 1'b0;
			wra_reg <= 16'h0000;
			wd_reg <= 8'h00;
			go_reg <= 1'b0;
			code_reg <= 8'h00;
			top_reg <= 8'h00;
			chl_reg <= 1'b0;
			ch_reg <= 32'h0;
			avl_reg <= 1'b0;
			avg_reg <= 8'h00;
			err_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			idx_reg <= idx_next;
			init_reg <= init_next;
			dev_reg <= dev_next;
			ra_reg <= ra_next;
			dat_reg <= dat_next;
			crc_reg <= crc_next;
			cnt_reg <= cnt_next;
			last_reg <= last_next;
			tx_reg <= tx_next;
			txv_reg <= txv_next;
			rde_reg <= rde_next;
			rda_reg <= rda_next;
			wre_reg <= wre_next;
			wra_reg <= wra_next;
			wd_reg <= wd_next;
			go_reg <= go_next;
			code_reg <= code_next;
			top_reg <= top_next;
			chl_reg <= chl_next;
			ch_reg <= ch_next;
			avl_reg <= avl_next;
			avg_reg <= avg_next;
			err_reg <= err_next;
		end
	end

	assign lk.rep_byte = tx_reg;
	assign lk.rep_valid = txv_reg;
	assign rd_en = rde_reg;
	assign rd_addr = rda_reg;
	assign wr_en = wre_reg;
	assign wr_addr = wra_reg;
	assign wr_data = wd_reg;
	assign cmd_go = go_reg;
	assign cmd_code = code_reg;
	assign cmd_top_addr = top_reg;
	assign chsel_load = chl_reg;
	assign chsel_value = ch_reg;
	assign avg_load = avl_reg;
	assign avg_value = avg_reg;
	assign comm_err = err_reg;
endmodule

// >>> src/fcrc_host_end.sv
`timescale 1ns/1ns
`include "fcrc_map.svh"
module fcrc_host_end (
	input wire logic clock, // 125 MHz
	input wire logic rst_b, // async reset, active low
	fcrc_link_if.host lk, // frame link
	input wire logic send_go, // start a command frame
	input wire logic [7:0] send_init, // first byte; bit 7 forced to 1
	input wire logic [7:0] send_dev, // device address or group id
	input wire logic [15:0] send_reg, // register address
	input wire logic [63:0] send_data, // payload, first byte in 7:0
	output logic busy, // frame being sent
	output logic rep_strobe, // reply payload byte
	output logic [7:0] rep_data, // reply payload value
	output logic rep_done, // reply frame ended
	output logic rep_err // reply had bad check or wrong kind
);
	fcrc_pkg::fcrc_host_st_e st_reg, st_next;
	logic [7:0] init_reg, init_next, dev_reg, dev_next, idx_reg, idx_next;
	logic [15:0] ra_reg, ra_next, crc_reg, crc_next;
	logic [63:0] dat_reg, dat_next;
	logic [7:0] tx_reg, tx_next;
	logic txv_reg, txv_next, busy_reg, busy_next;
	logic [7:0] o_dat, end_d, b;
	logic has_dev;

	assign has_dev = init_reg[`FCRC_REQ_HI:`FCRC_REQ_MID] != `FCRC_REQ_BCAST;
	assign o_dat = 8'(has_dev) + 8'(init_reg[`FCRC_ASIZE_BIT]) + `FCRC_HDR_MIN;
	assign end_d = o_dat + {4'h0, fcrc_pkg::data_count(init_reg[`FCRC_DSIZE_HI:0])};

	always_comb begin
		st_next = st_reg;
		init_next = init_reg;
		dev_next = dev_reg;
		ra_next = ra_reg;
		dat_next = dat_reg;
		idx_next = idx_reg;
		crc_next = crc_reg;
		busy_next = busy_reg;
		tx_next = tx_reg;
		txv_next = 1'b0;
		b = init_reg;
		unique case (st_reg)
			fcrc_pkg::FCRC_H_IDLE: begin
				if (send_go) begin
					init_next = {1'b1, send_init[`FCRC_RLEN_HI:0]};
					dev_next = send_dev;
					ra_next = send_reg;
					dat_next = send_data;
					idx_next = 8'h00;
					busy_next = 1'b1;
					st_next = fcrc_pkg::FCRC_H_SEND;
				end
			end
			fcrc_pkg::FCRC_H_SEND: begin
				if (idx_reg == end_d) begin
					crc_next = fcrc_pkg::crc_aug(crc_reg);
					tx_next = crc_next[7:0];
					st_next = fcrc_pkg::FCRC_H_CRCH;
				end else begin
					if (idx_reg == 8'h00) begin
						b = init_reg;
					end else if (has_dev && idx_reg == 8'h01) begin
						b = dev_reg;
					end else if (idx_reg < o_dat) begin
						b = (idx_reg == o_dat - 8'h01) ? ra_reg[7:0] : ra_reg[15:8];
					end else begin
						b = dat_reg[7:0];
						dat_next = dat_reg >> 8;
					end
					crc_next = fcrc_pkg::crc_byte((idx_reg == 8'h00) ? `FCRC_CRC_INIT : crc_reg, b);
					tx_next = b;
				end
				txv_next = 1'b1;
				idx_next = idx_reg + 8'h01;
			end
			fcrc_pkg::FCRC_H_CRCH: begin
				tx_next = crc_reg[15:8];
				txv_next = 1'b1;
				busy_next = 1'b0;
				st_next = fcrc_pkg::FCRC_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= fcrc_pkg::FCRC_H_IDLE;
			init_reg <= 8'h00;
			dev_reg <= 8'h00;
			ra_reg <= 16'h0000;
			dat_reg <= 64'h0;
			idx_reg <= 8'h00;
			crc_reg <= `FCRC_CRC_INIT;
			tx_reg <= 8'h00;
			txv_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			init_reg <= init_next;
			dev_reg <= dev_next;
			ra_reg <= ra_next;
			dat_reg <= dat_next;
			idx_reg <= idx_next;
			crc_reg <= crc_next;
			tx_reg <= tx_next;
			txv_reg <= txv_next;
			busy_reg <= busy_next;
		end
	end

	// Reply side
	logic [7:0] rinit_reg, rinit_next, ridx_reg, ridx_next, rtot, rd_reg, rd_next;
	logic [15:0] rcrc_reg, rcrc_next;
	logic rs_reg, rs_next, rdone_reg, rdone_next, rerr_reg, rerr_next;

	assign rtot = {1'b0, rinit_reg[`FCRC_RLEN_HI:0]} + `FCRC_REPLY_OVH;

	always_comb begin
		rinit_next = rinit_reg;
		ridx_next = ridx_reg;
		rcrc_next = rcrc_reg;
		rd_next = rd_reg;
		rs_next = 1'b0;
		rdone_next = 1'b0;
		rerr_next = 1'b0;
		if (lk.rep_valid) begin
			rcrc_next = fcrc_pkg::crc_byte((ridx_reg == 8'h00) ? `FCRC_CRC_INIT : rcrc_reg, lk.rep_byte);
			ridx_next = ridx_reg + 8'h01;
			if (ridx_reg == 8'h00) begin
				rinit_next = lk.rep_byte;
			end else if (ridx_reg < rtot - `FCRC_CRC_BYTES) begin
				rs_next = 1'b1;
				rd_next = lk.rep_byte;
			end
			if (ridx_reg != 8'h00 && ridx_reg == rtot - 8'h01) begin
				ridx_next = 8'h00;
				rdone_next = 1'b1;
				rerr_next = (rcrc_next != `FCRC_CRC_INIT) || rinit_reg[`FCRC_KIND_BIT];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rinit_reg <= 8'h00;
			ridx_reg <= 8'h00;
			rcrc_reg <= `FCRC_CRC_INIT;
			rd_reg <= 8'h00;
			rs_reg <= 1'b0;
			rdone_reg <= 1'b0;
			rerr_reg <= 1'b0;
		end else begin
			rinit_reg <= rinit_next;
			ridx_reg <= ridx_next;
			rcrc_reg <= rcrc_next;
			rd_reg <= rd_next;
			rs_reg <= rs_next;
			rdone_reg <= rdone_next;
			rerr_reg <= rerr_next;
		end
	end

	assign lk.cmd_byte = tx_reg;
	assign lk.cmd_valid = txv_reg;
	assign busy = busy_reg;
	assign rep_strobe = rs_reg;
	assign rep_data = rd_reg;
	assign rep_done = rdone_reg;
	assign rep_err = rerr_reg;
endmodule

// >>> src/fcrc_link_if.sv
`timescale 1ns/1ns
interface fcrc_link_if (
	input wire logic clock, // shared clock
	input wire logic rst_b // async reset, active low
);
	logic [7:0] cmd_byte;
	logic cmd_valid;
	logic [7:0] rep_byte;
	logic rep_valid;

	modport host (input clock, input rst_b, output cmd_byte, output cmd_valid, input rep_byte, input rep_valid);
	modport device (input clock, input rst_b, input cmd_byte, input cmd_valid, output rep_byte, output rep_valid);
endinterface

// >>> src/fcrc_map.svh
`ifndef FCRC_MAP_SVH
`define FCRC_MAP_SVH

// First frame byte layout
`define FCRC_KIND_BIT 7
`define FCRC_REQ_HI 6
`define FCRC_REQ_MID 5
`define FCRC_NOREPLY_BIT 4
`define FCRC_ASIZE_BIT 3
`define FCRC_DSIZE_HI 2
`define FCRC_RLEN_HI 6

// Request kinds, taken from bits 6:5 of the first byte
`define FCRC_REQ_SINGLE 2'h0
`define FCRC_REQ_GROUP 2'h1
`define FCRC_REQ_BCAST 2'h3

// Length encodings
`define FCRC_DSIZE_EIGHT 3'h7
`define FCRC_EIGHT_BYTES 4'h8
`define FCRC_RLEN_SEVEN 7'h06
`define FCRC_RLEN_EIGHT 7'h07
`define FCRC_HDR_MIN 8'h02
`define FCRC_CRC_BYTES 8'h02
`define FCRC_REPLY_OVH 8'h04

// Command register and its payload positions
`define FCRC_REG_CMD 16'h0002
`define FCRC_CMD_CHSEL_MIN 4'h6
`define FCRC_CMD_AVG_MIN 4'h7

`define FCRC_CRC_INIT 16'h0000
`define FCRC_ZERO_BYTE 8'h00

`endif

// >>> src/fcrc_pkg.sv
package fcrc_pkg;
	`include "fcrc_map.svh"

	typedef enum logic [2:0] {
		FCRC_D_RX, FCRC_D_WRITE, FCRC_D_RHDR, FCRC_D_RREQ, FCRC_D_RWAIT, FCRC_D_RCAP, FCRC_D_CRCL, FCRC_D_CRCH
	} fcrc_dev_st_e;

	typedef enum logic [1:0] {FCRC_H_IDLE, FCRC_H_SEND, FCRC_H_CRCH} fcrc_host_st_e;

	// One byte, eight serial steps, least significant bit first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[0] ^ d[i], r[15], r[14] ^ r[0], r[13:2], r[1] ^ r[0]};
		end
		return r;
	endfunction

	// Sixteen trailing zero bits close the augmented form
	function automatic logic [15:0] crc_aug(input logic [15:0] c);
		return crc_byte(crc_byte(c, `FCRC_ZERO_BYTE), `FCRC_ZERO_BYTE);
	endfunction

	// Size code 7 stands for eight bytes; seven cannot be encoded
	function automatic logic [3:0] data_count(input logic [2:0] code);
		return (code == `FCRC_DSIZE_EIGHT) ? `FCRC_EIGHT_BYTES : {1'b0, code};
	endfunction
endpackage

// >>> tb/fcrc_link_asserts.sv
`timescale 1ns/1ns
module fcrc_link_asserts (
	input wire logic clock, // shared clock
	input wire logic rst_b, // async reset, active low
	input wire logic [7:0] cmd_byte, // host to device byte
	input wire logic cmd_valid, // host byte strobe
	input wire logic [7:0] rep_byte, // device to host byte
	input wire logic rep_valid // device byte strobe
);
	logic [15:0] cmd_crc_reg;
	logic [15:0] rep_crc_reg;
	logic [7:0] cmd_cnt_reg;
	logic [7:0] rep_cnt_reg;
	logic [7:0] cmd_len_reg;
	logic [7:0] rep_len_reg;
	logic [15:0] cmd_crc_step;
	logic [15:0] rep_crc_step;
	logic [7:0] cmd_len_now;
	logic [7:0] rep_len_now;
	logic cmd_last;
	logic rep_last;
	logic rep_lo;

	function automatic logic [15:0] step8(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[0] ^ d[i], r[15], r[14] ^ r[0], r[13:2], r[1] ^ r[0]};
		end
		return r;
	endfunction

	// Frame lengths come from the first byte only, so a wrong field shows as a remainder fault
	always_comb begin
		cmd_len_now = (cmd_cnt_reg == 8'h00) ? 8'h04 + {7'h00, cmd_byte[6:5] != 2'h3} + {7'h00, cmd_byte[3]}
			+ ((cmd_byte[2:0] == 3'h7) ? 8'h08 : {5'h00, cmd_byte[2:0]}) : cmd_len_reg;
		rep_len_now = (rep_cnt_reg == 8'h00) ? {1'b0, rep_byte[6:0]} + 8'h04 : rep_len_reg;
		cmd_crc_step = step8((cmd_cnt_reg == 8'h00) ? 16'h0000 : cmd_crc_reg, cmd_byte);
		rep_crc_step = step8((rep_cnt_reg == 8'h00) ? 16'h0000 : rep_crc_reg, rep_byte);
		cmd_last = cmd_valid && (cmd_cnt_reg + 8'h01 == cmd_len_now);
		rep_last = rep_valid && (rep_cnt_reg + 8'h01 == rep_len_now);
		rep_lo = rep_valid && (rep_cnt_reg + 8'h02 == rep_len_now);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cmd_crc_reg <= 16'h0000;
			rep_crc_reg <= 16'h0000;
			cmd_cnt_reg <= 8'h00;
			rep_cnt_reg <= 8'h00;
			cmd_len_reg <= 8'h00;
			rep_len_reg <= 8'h00;
		end else begin
			if (cmd_valid) begin
				cmd_crc_reg <= cmd_crc_step;
				cmd_len_reg <= cmd_len_now;
				cmd_cnt_reg <= cmd_last ? 8'h00 : cmd_cnt_reg + 8'h01;
			end
			if (rep_valid) begin
				rep_crc_reg <= rep_crc_step;
				rep_len_reg <= rep_len_now;
				rep_cnt_reg <= rep_last ? 8'h00 : rep_cnt_reg + 8'h01;
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence s_cmd_open;
		cmd_valid && !cmd_last;
	endsequence
	sequence s_rep_head;
		rep_valid && rep_cnt_reg == 8'h00;
	endsequence
	property p_rep_crc_pair;
		rep_lo |=> rep_last;
	endproperty

	AST_CMD_ZERO_REM: assert property (cmd_last |-> cmd_crc_step == 16'h0000)
		else $error("command frame remainder not zero");
	AST_REP_ZERO_REM: assert property (rep_last |-> rep_crc_step == 16'h0000)
		else $error("reply frame remainder not zero");
	AST_CMD_KIND: assert property (cmd_valid && cmd_cnt_reg == 8'h00 |-> cmd_byte[7])
		else $error("command frame kind bit clear");
	AST_REP_KIND: assert property (s_rep_head |-> !rep_byte[7])
		else $error("reply frame kind bit set");
	AST_REP_NOT_SEVEN: assert property (s_rep_head |-> rep_byte[6:0] != 7'h06)
		else $error("reply announces seven bytes");
	AST_CMD_CONTIG: assert property (s_cmd_open |=> cmd_valid)
		else $error("command frame bytes not consecutive");
	AST_REP_CRC_PAIR: assert property (p_rep_crc_pair)
		else $error("reply check bytes not paired");
	AST_RESET_IDLE: assert property ($rose(rst_b) |-> !cmd_valid && !rep_valid)
		else $error("link active right after reset");
endmodule

// >>> tb/test_frame_payload_crc16_unit.sv
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_frame_payload_crc16_unit;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic send_go = 1'b0;
	logic [7:0] send_init = 8'h00;
	logic [7:0] send_dev = 8'h00;
	logic [15:0] send_reg = 16'h0000;
	logic [63:0] send_data = 64'h0;
	logic [7:0] rd_data = 8'h00;
	logic busy, rep_strobe, rep_done, rep_err, rd_en, wr_en, cmd_go, chsel_load, avg_load, comm_err, wr_en_b, comm_err_b;
	logic [7:0] rep_data, wr_data, cmd_code, cmd_top_addr, avg_value;
	logic [15:0] rd_addr, wr_addr;
	logic [31:0] chsel_value;
	logic [7:0] cmd_q[$], rep_q[$], exp_q[$], host_q[$];
	logic [23:0] wr_q[$];
	logic [57:0] go_q[$];
	logic last_err, err_h, rep_done_h, rep_err_h;
	int miscompares = 0, tests_run = 0, bad_err = 0, bad_wr = 0, done_n = 0, good_err = 0, done_h = 0;

	fcrc_link_if lk_main (.clock(clock), .rst_b(rst_b));
	fcrc_link_if lk_bad (.clock(clock), .rst_b(rst_b));
	fcrc_link_if lk_rep (.clock(clock), .rst_b(rst_b));
	always #4 clock = ~clock;

	fcrc_host_end u_fcrc_host_end (.clock(clock), .rst_b(rst_b), .lk(lk_main), .send_go(send_go), .send_init(send_init),
		.send_dev(send_dev), .send_reg(send_reg), .send_data(send_data), .busy(busy), .rep_strobe(rep_strobe),
		.rep_data(rep_data), .rep_done(rep_done), .rep_err(rep_err));
	fcrc_device_end u_fcrc_device_end (.clock(clock), .rst_b(rst_b), .lk(lk_main), .my_addr(8'h03), .my_group(8'h05),
		.rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.cmd_go(cmd_go), .cmd_code(cmd_code), .cmd_top_addr(cmd_top_addr), .chsel_load(chsel_load),
		.chsel_value(chsel_value), .avg_load(avg_load), .avg_value(avg_value), .comm_err(comm_err));
	// Second device only sees frames that the bench drives, one with a spoiled check byte and one intact
	fcrc_device_end u_fcrc_device_end_bad (.clock(clock), .rst_b(rst_b), .lk(lk_bad), .my_addr(8'h03), .my_group(8'h05),
		.rd_data(8'h00), .rd_en(), .rd_addr(), .wr_en(wr_en_b), .wr_addr(), .wr_data(), .cmd_go(), .cmd_code(),
		.cmd_top_addr(), .chsel_load(), .chsel_value(), .avg_load(), .avg_value(), .comm_err(comm_err_b));
	// Second host only hears reply frames that the bench builds, good or spoiled
	fcrc_host_end u_fcrc_host_end_rep (.clock(clock), .rst_b(rst_b), .lk(lk_rep), .send_go(1'b0),
		.send_init(8'h00), .send_dev(8'h00), .send_reg(16'h0000), .send_data(64'h0), .busy(), .rep_strobe(),
		.rep_data(), .rep_done(rep_done_h), .rep_err(rep_err_h));
	fcrc_link_asserts u_fcrc_link_asserts (.clock(clock), .rst_b(rst_b), .cmd_byte(lk_main.cmd_byte),
		.cmd_valid(lk_main.cmd_valid), .rep_byte(lk_main.rep_byte), .rep_valid(lk_main.rep_valid));

	always @(posedge clock) begin
		if (lk_main.cmd_valid === 1'b1) cmd_q.push_back(lk_main.cmd_byte);
		if (lk_main.rep_valid === 1'b1) rep_q.push_back(lk_main.rep_byte);
		if (rep_strobe === 1'b1) host_q.push_back(rep_data);
		if (wr_en === 1'b1) wr_q.push_back({wr_addr, wr_data});
		if (cmd_go === 1'b1) go_q.push_back({chsel_load, avg_load, cmd_code, cmd_top_addr, chsel_value, avg_value});
		if (rep_done === 1'b1) begin
			done_n++;
			last_err = rep_err;
		end
		// Register file stand-in: outside the read slot the value keeps toggling
		rd_data <= (rd_en === 1'b1) ? rd_addr[7:0] ^ 8'hA5 : ~rd_data;
		bad_err += (comm_err_b === 1'b1);
		bad_wr += (wr_en_b === 1'b1);
		good_err += (comm_err === 1'b1);
		if (rep_done_h === 1'b1) begin
			done_h++;
			err_h = rep_err_h;
		end
	end

	function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
		logic [15:0] r;
		r = 16'h0000;
		foreach (q[k]) begin
			for (int i = 0; i < 8; i++) begin
				r = {r[0] ^ q[k][i], r[15], r[14] ^ r[0], r[13:2], r[1] ^ r[0]};
			end
		end
		return r;
	endfunction

	task automatic send(input logic [7:0] ini, input logic [7:0] dev, input logic [15:0] rg, input logic [63:0] d);
		logic [15:0] r;
		int n;
		n = (ini[2:0] == 3'h7) ? 8 : ini[2:0];
		exp_q = {ini};
		if (ini[6:5] != 2'h3) exp_q.push_back(dev);
		if (ini[3]) exp_q.push_back(rg[15:8]);
		exp_q.push_back(rg[7:0]);
		for (int i = 0; i < n; i++) exp_q.push_back(d[8*i +: 8]);
		r = crc_of({exp_q, 8'h00, 8'h00});
		exp_q.push_back(r[7:0]);
		exp_q.push_back(r[15:8]);
		cmd_q = {};
		rep_q = {};
		host_q = {};
		wr_q = {};
		go_q = {};
		send_init <= ini;
		send_dev <= dev;
		send_reg <= rg;
		send_data <= d;
		send_go <= 1'b1;
		@(posedge clock);
		send_go <= 1'b0;
		for (int k = 0; k < 60; k++) begin
			@(posedge clock);
			if (busy === 1'b0) break;
		end
		// The device has no done flag for writes; a reply takes under 30 cycles
		repeat (30) @(posedge clock);
		`CHK(cmd_q.size(), exp_q.size())
		foreach (exp_q[i]) `CHK(cmd_q[i], exp_q[i])
	endtask

	task automatic drive_bad(input logic [7:0] hi);
		logic [7:0] f[6];
		f = '{8'h91, 8'h03, 8'h07, 8'h05, 8'h1E, hi};
		foreach (f[i]) begin
			lk_bad.cmd_byte <= f[i];
			lk_bad.cmd_valid <= 1'b1;
			@(posedge clock);
		end
		lk_bad.cmd_valid <= 1'b0;
		lk_bad.cmd_byte <= 8'h5A;
		repeat (10) @(posedge clock);
	endtask

	task automatic drive_rep(input logic [7:0] flip);
		logic [7:0] q[$];
		logic [15:0] r;
		q = {8'h00, 8'hAA};
		r = crc_of({q, 8'h00, 8'h00});
		q.push_back(r[7:0]);
		q.push_back(r[15:8] ^ flip);
		foreach (q[i]) begin
			lk_rep.rep_byte <= q[i];
			lk_rep.rep_valid <= 1'b1;
			@(posedge clock);
		end
		lk_rep.rep_valid <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		print_verdict;
	end

	initial begin
		int n;
		lk_bad.cmd_valid = 1'b0;
		lk_bad.cmd_byte = 8'h00;
		lk_rep.rep_valid = 1'b0;
		lk_rep.rep_byte = 8'h00;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		send(8'h91, 8'h03, 16'h0007, 64'h05);
		`CHK(exp_q[4], 8'h1E)
		`CHK(exp_q[5], 8'hCF)
		`CHK(wr_q[0], 24'h000705)
		send(8'hBA, 8'h05, 16'h0120, 64'hBBAA);
		`CHK(wr_q.size(), 2)
		`CHK(wr_q[1], 24'h0121BB)
		send(8'hF1, 8'h00, 16'h0030, 64'h77);
		`CHK(wr_q[0], 24'h003077)
		for (int j = 0; j < 2; j++) begin
			// A request for seven bytes must come back as eight
			send(j ? 8'hA1 : 8'h81, j ? 8'h05 : 8'h03, j ? 16'h0020 : 16'h0010, j ? 64'h06 : 64'h01);
			n = j ? 8 : 2;
			`CHK(rep_q.size(), n + 3)
			`CHK(rep_q[0], j ? 8'h07 : 8'h01)
			`CHK(done_n, j + 1)
			`CHK(last_err, 1'b0)
			for (int i = 0; i < n; i++) begin
				`CHK(host_q[i], (j ? 8'h20 : 8'h10) + 8'(i) ^ 8'hA5)
			end
		end
		for (int j = 0; j < 3; j++) begin
			send(j == 0 ? 8'h92 : (j == 1 ? 8'h96 : 8'h97), 8'h03, 16'h0002, 64'h8877665544332211);
			`CHK(go_q.size(), 1)
			`CHK(go_q[0][55:40], 16'h1122)
			`CHK(go_q[0][57:56], j == 0 ? 2'h0 : (j == 1 ? 2'h2 : 2'h3))
			if (j > 0) `CHK(go_q[0][39:8], 32'h33445566)
			if (j == 2) `CHK(go_q[0][7:0], 8'h77)
			`CHK(wr_q.size(), 0)
		end
		drive_bad(8'hCE);
		`CHK(bad_err, 1)
		`CHK(bad_wr, 0)
		drive_bad(8'hCF);
		`CHK(bad_wr, 1)
		`CHK(bad_err, 1)
		`CHK(good_err, 0)
		drive_rep(8'h00);
		`CHK(done_h, 1)
		`CHK(err_h, 1'b0)
		drive_rep(8'h01);
		`CHK(done_h, 2)
		`CHK(err_h, 1'b1)
		print_verdict;
	end
endmodule
